/* bench/bus_master_model.sv */
// bus master model issuing completed register writes and reads
`timescale 1ns/1ps
module bus_master_model
   import buck_ctrl_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic [7:0] i_rd_data,
   output buck_ctrl_pkg::bus_req_type o_bus
);
   initial o_bus = '0;
   // released bus shows inverted fields so stale values never look valid
   task automatic wr_reg(input logic [4:0] addr, input logic [7:0] data);
      @(negedge i_ref_clk);
      o_bus = '{wr: 1'b1, rd: 1'b0, addr: addr, data: data};
      @(negedge i_ref_clk);
      o_bus = '{wr: 1'b0, rd: 1'b0, addr: ~addr, data: ~data};
      @(negedge i_ref_clk);
   endtask : wr_reg
   task automatic rd_reg(input logic [4:0] addr, output logic [7:0] data);
      @(negedge i_ref_clk);
      o_bus = '{wr: 1'b0, rd: 1'b1, addr: addr, data: 8'h00};
      @(negedge i_ref_clk);
      data = i_rd_data;
      o_bus = '{wr: 1'b0, rd: 1'b0, addr: ~addr, data: 8'hFF};
   endtask : rd_reg
endmodule : bus_master_model

/* bench/tb_top.sv */
// self-checking bench for the converter power state and mode control
`timescale 1ns/1ps
`include "buck_ctrl_regs.svh"
module tb_top;
   import buck_ctrl_pkg::*;
   logic i_ref_clk = 1'b0;
   logic i_reset = 1'b1;
   sense_type sense = '0;
   bus_req_type bus;
   logic [7:0] rd_data, level_code;
   power_state_type pwr;
   op_mode_type op;
   logic sw_en, hiz, auto_byp;
   int num_errors = 0;
   int tests_run = 0;
   int cycles = 0;
   // {offset, data} writes and the power state each must leave
   // every entry but the first and the last changes the state, so an ignored write shows up
   logic [12:0] steps [14] = '{13'h1C00, 13'h0304, 13'h1C00, 13'h0305, 13'h1C00, 13'h0002,
      13'h0000, 13'h1C00, 13'h0301, 13'h1C00, 13'h0300, 13'h1C00, 13'h1C80, 13'h1C40};
   power_state_type exp_pwr [14] = '{PWR_ACTIVE, PWR_STANDBY, PWR_ACTIVE, PWR_STANDBY,
      PWR_ACTIVE, PWR_STANDBY, PWR_LOW_POWER, PWR_ACTIVE, PWR_LOW_POWER, PWR_ACTIVE,
      PWR_LOW_POWER, PWR_ACTIVE, PWR_LOW_POWER, PWR_LOW_POWER};
   logic [12:0] byp [3] = '{13'h007F, 13'h03FE, 13'h03FF};
   always #10 i_ref_clk = ~i_ref_clk;
   buck_mode_power_state_ctrl dut (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_bus(bus),
      .i_sense(sense), .o_rd_data(rd_data), .o_power_state(pwr), .o_op_mode(op),
      .o_switch_enable(sw_en), .o_switch_node_hiz(hiz), .o_auto_bypass_en(auto_byp),
      .o_output_level_code(level_code));
   bus_master_model master (.i_ref_clk(i_ref_clk), .i_rd_data(rd_data), .o_bus(bus));
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic rchk(input logic [4:0] a, input logic [7:0] exp);
      logic [7:0] v;
      master.rd_reg(a, v);
      chk("read data", v, exp);
   endtask : rchk
   task automatic state(input power_state_type p, input op_mode_type m, input logic s);
      chk("power state", 8'(pwr), 8'(p));
      chk("op mode", 8'(op), 8'(m));
      chk("switch enable", 8'(sw_en), 8'(s));
      chk("switch hiz", 8'(hiz), 8'(!s));
   endtask : state
   task automatic mode_after(input logic [4:0] s, input op_mode_type m);
      sense = s;
      // sense filter plus pfm decision plus output register
      repeat (8) @(negedge i_ref_clk);
      chk("op mode", 8'(op), 8'(m));
   endtask : mode_after
   task automatic final_report;
      $display("checks %0d errors %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : final_report
   always @(posedge i_ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         num_errors++;
         final_report();
      end
   end
   initial begin
      repeat (6) @(negedge i_ref_clk);
      i_reset = 1'b0;
      repeat (2) @(negedge i_ref_clk);
      state(PWR_LOW_POWER, OP_OFF, 1'b0);
      rchk(`OFS_POWER_STATE_SELECT, 8'h80);
      rchk(`OFS_CONVERTER_CONFIG, 8'h00);
      rchk(5'h02, 8'h00);
      master.wr_reg(`OFS_POWER_STATE_SELECT, 8'h00);
      state(PWR_ACTIVE, OP_FORCED_PWM, 1'b1);
      master.wr_reg(`OFS_LEVEL_COARSE, 8'hB5);
      chk("level code", level_code, 8'h6A);
      rchk(`OFS_LEVEL_COARSE, 8'h35);
      rchk(`OFS_LEVEL_FINE, 8'h6A);
      master.wr_reg(`OFS_CONVERTER_CONFIG, 8'h20);
      state(PWR_ACTIVE, OP_AUTO_PWM, 1'b1);
      chk("auto bypass", 8'(auto_byp), 8'h01);
      mode_after(5'b01001, OP_AUTO_PWM);
      mode_after(5'b01011, OP_AUTO_PFM);
      mode_after(5'b01110, OP_AUTO_PWM);
      mode_after(5'b01011, OP_AUTO_PFM);
      master.wr_reg(`OFS_CONVERTER_CONFIG, 8'h30);
      state(PWR_ACTIVE, OP_FORCED_BYPASS, 1'b1);
      chk("auto bypass", 8'(auto_byp), 8'h00);
      for (int i = 0; i < 3; i++) begin
         master.wr_reg(`OFS_CONVERTER_CONFIG, 8'h20);
         // neutral level first, else the previous bypass level masks this one
         master.wr_reg(`OFS_LEVEL_FINE, 8'h80);
         master.wr_reg(byp[i][12:8], byp[i][7:0]);
         chk("op mode", 8'(op), 8'(OP_FORCED_BYPASS));
      end
      master.wr_reg(`OFS_LEVEL_FINE, 8'h80);
      mode_after(5'b11011, OP_AUTO_PWM);
      for (int i = 0; i < 14; i++) begin
         master.wr_reg(steps[i][12:8], steps[i][7:0]);
         chk("power state", 8'(pwr), 8'(exp_pwr[i]));
         chk("switch enable", 8'(sw_en), 8'(exp_pwr[i] == PWR_ACTIVE));
      end
      i_reset = 1'b1;
      @(negedge i_ref_clk);
      state(PWR_SHUTDOWN, OP_OFF, 1'b0);
      i_reset = 1'b0;
      repeat (2) @(negedge i_ref_clk);
      state(PWR_LOW_POWER, OP_OFF, 1'b0);
      rchk(`OFS_LEVEL_FINE, 8'h00);
      rchk(`OFS_CONVERTER_CONFIG, 8'h00);
      rchk(`OFS_POWER_STATE_SELECT, 8'h80);
      final_report();
   end
endmodule : tb_top

/* verilog/buck_ctrl_pkg.sv */
// types shared by the converter control block
package buck_ctrl_pkg;
   typedef enum logic [3:0] {
      PWR_SHUTDOWN = 4'b0001,
      PWR_LOW_POWER = 4'b0010,
      PWR_STANDBY = 4'b0100,
      PWR_ACTIVE = 4'b1000
   } power_state_type;
   typedef enum logic [4:0] {
      OP_OFF = 5'b00001,
      OP_FORCED_PWM = 5'b00010,
      OP_AUTO_PWM = 5'b00100,
      OP_AUTO_PFM = 5'b01000,
      OP_FORCED_BYPASS = 5'b10000
   } op_mode_type;
   // analog comparator results, already thresholded by the analog side
   typedef struct packed {
      logic transient;
      logic at_target;
      logic heavy_load;
      logic headroom_ok;
      logic light_load;
   } sense_type;
   // one completed access from the serial front-end slave
   typedef struct packed {
      logic wr;
      logic rd;
      logic [4:0] addr;
      logic [7:0] data;
   } bus_req_type;
   typedef struct packed {
      sense_type sync1;
      sense_type sync2;
      sense_type sync3;
      sense_type sense;
      logic [7:0] level;
      logic [7:0] config_r;
      logic [7:0] psel;
      power_state_type pwr;
      op_mode_type op_mode;
      logic pfm;
      logic pwm_hold;
      logic auto_bypass;
      logic switch_en;
      logic [7:0] rd_data;
   } ctrl_state_type;
endpackage : buck_ctrl_pkg

/* verilog/buck_ctrl_regs.svh */
// register offsets, field positions, reset values for the converter control
`ifndef BUCK_CTRL_REGS_SVH
`define BUCK_CTRL_REGS_SVH
`define OFS_LEVEL_COARSE 5'h00
`define OFS_CONVERTER_CONFIG 5'h01
`define OFS_LEVEL_FINE 5'h03
`define OFS_POWER_STATE_SELECT 5'h1C
`define CFG_MODE_BIT 5
`define CFG_BYPASS_BIT 4
`define PSEL_MSB 7
`define PSEL_LSB 6
`define PSEL_ACTIVE 2'h0
`define PSEL_LOW_POWER 2'h2
`define LEVEL7_LOW_POWER 7'h00
`define LEVEL7_STANDBY 7'h02
`define LEVEL7_BYPASS 7'h7F
`define RST_LEVEL 8'h00
`define RST_CONFIG 8'h00
`define RST_PSEL 8'h80
`define SYNC_STAGES 3
`endif

/* verilog/buck_mode_power_state_ctrl.sv */
// power state and switching mode control of the step-down converter
`timescale 1ns/1ps
`include "buck_ctrl_regs.svh"
module buck_mode_power_state_ctrl (
   input wire logic i_ref_clk,
   input wire logic i_reset,
   input wire buck_ctrl_pkg::bus_req_type i_bus,
   input wire buck_ctrl_pkg::sense_type i_sense,
   output logic [7:0] o_rd_data,
   output buck_ctrl_pkg::power_state_type o_power_state,
   output buck_ctrl_pkg::op_mode_type o_op_mode,
   output logic o_switch_enable,
   output logic o_switch_node_hiz,
   output logic o_auto_bypass_en,
   output logic [7:0] o_output_level_code
);
   import buck_ctrl_pkg::*;

   ctrl_state_type s_reg;
   ctrl_state_type s_next;
   logic forced_bypass;
   logic mode_rise;
   power_state_type level_pwr;

   // coarse data[6:0] and fine data[7:1] name the same 7-bit level step
   function automatic power_state_type level_to_pwr(input logic [6:0] lvl7,
                                                     input power_state_type cur);
      if (lvl7 == `LEVEL7_LOW_POWER) begin
         level_to_pwr = PWR_LOW_POWER;
      end else if (lvl7 == `LEVEL7_STANDBY) begin
         level_to_pwr = PWR_STANDBY;
      end else begin
         level_to_pwr = cur;
      end
   endfunction : level_to_pwr

   function automatic logic bypass_req(input logic [7:0] cfg, input logic [7:0] lvl);
      bypass_req = cfg[`CFG_BYPASS_BIT] || (lvl[7:1] == `LEVEL7_BYPASS);
   endfunction : bypass_req

   assign forced_bypass = bypass_req(s_reg.config_r, s_reg.level);

   always_comb begin
      s_next = s_reg;
      mode_rise = 1'b0;
      level_pwr = s_reg.pwr;
      // comparators are asynchronous to this clock; accept a change only when
      // stages two and three agree, so a glitch shorter than a cycle is dropped
      s_next.sync1 = i_sense;
      s_next.sync2 = s_reg.sync1;
      s_next.sync3 = s_reg.sync2;
      s_next.sense = (s_reg.sense & ~(s_reg.sync2 ~^ s_reg.sync3))
         | (s_reg.sync3 & (s_reg.sync2 ~^ s_reg.sync3));

      // register writes; power state and pwm hold follow them in the same cycle, mode decode from the next cycle on
      if (i_bus.wr) begin
         if (i_bus.addr == `OFS_LEVEL_COARSE) begin
            s_next.level = {i_bus.data[6:0], 1'b0};
            level_pwr = level_to_pwr(i_bus.data[6:0], s_reg.pwr);
         end else if (i_bus.addr == `OFS_CONVERTER_CONFIG) begin
            s_next.config_r = i_bus.data;
            mode_rise = i_bus.data[`CFG_MODE_BIT] && !s_reg.config_r[`CFG_MODE_BIT];
         end else if (i_bus.addr == `OFS_LEVEL_FINE) begin
            s_next.level = i_bus.data;
            level_pwr = level_to_pwr(i_bus.data[7:1], s_reg.pwr);
         end else if (i_bus.addr == `OFS_POWER_STATE_SELECT) begin
            s_next.psel = i_bus.data;
            if (i_bus.data[`PSEL_MSB:`PSEL_LSB] == `PSEL_ACTIVE) begin
               level_pwr = PWR_ACTIVE;
            end else if (i_bus.data[`PSEL_MSB:`PSEL_LSB] == `PSEL_LOW_POWER) begin
               level_pwr = PWR_LOW_POWER;
            end
         end
      end

      case (s_reg.pwr)
         PWR_SHUTDOWN: begin
            s_next.pwr = PWR_LOW_POWER;
         end
         default: begin
            s_next.pwr = level_pwr;
         end
      endcase

      // reads return the shared level register through either window
      if (i_bus.rd) begin
         if (i_bus.addr == `OFS_LEVEL_COARSE) begin
            s_next.rd_data = {1'b0, s_reg.level[7:1]};
         end else if (i_bus.addr == `OFS_CONVERTER_CONFIG) begin
            s_next.rd_data = s_reg.config_r;
         end else if (i_bus.addr == `OFS_LEVEL_FINE) begin
            s_next.rd_data = s_reg.level;
         end else if (i_bus.addr == `OFS_POWER_STATE_SELECT) begin
            s_next.rd_data = s_reg.psel;
         end else begin
            s_next.rd_data = 8'h00;
         end
      end

      // hold PWM until the output settles; a new cause wins over the clear
      if (s_reg.sense.transient || mode_rise
          || (s_reg.pwr != PWR_ACTIVE && s_next.pwr == PWR_ACTIVE)) begin
         s_next.pwm_hold = 1'b1;
      end else if (s_reg.sense.at_target) begin
         s_next.pwm_hold = 1'b0;
      end

      // entry and exit use separate comparators, which gives the hysteresis
      if (s_reg.pwr != PWR_ACTIVE || !s_reg.config_r[`CFG_MODE_BIT] || forced_bypass
          || s_reg.sense.transient || s_reg.sense.heavy_load) begin
         s_next.pfm = 1'b0;
      end else if (!s_reg.pwm_hold && s_reg.sense.at_target
                   && s_reg.sense.light_load && s_reg.sense.headroom_ok) begin
         s_next.pfm = 1'b1;
      end

      if (s_reg.pwr != PWR_ACTIVE) begin
         s_next.op_mode = OP_OFF;
      end else if (forced_bypass) begin
         s_next.op_mode = OP_FORCED_BYPASS;
      end else if (!s_reg.config_r[`CFG_MODE_BIT]) begin
         s_next.op_mode = OP_FORCED_PWM;
      end else if (s_reg.pfm) begin
         s_next.op_mode = OP_AUTO_PFM;
      end else begin
         s_next.op_mode = OP_AUTO_PWM;
      end
      s_next.switch_en = (s_reg.pwr == PWR_ACTIVE);
      s_next.auto_bypass = (s_reg.pwr == PWR_ACTIVE)
         && !s_reg.config_r[`CFG_BYPASS_BIT];
   end

   // reset stands for the I/O supply being absent; logic is then unpowered
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         s_reg <= '0;
         s_reg.level <= `RST_LEVEL;
         s_reg.config_r <= `RST_CONFIG;
         s_reg.psel <= `RST_PSEL;
         s_reg.pwr <= PWR_SHUTDOWN;
         s_reg.op_mode <= OP_OFF;
         s_reg.pwm_hold <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   assign o_rd_data = s_reg.rd_data;
   assign o_power_state = s_reg.pwr;
   assign o_op_mode = s_reg.op_mode;
   assign o_switch_enable = s_reg.switch_en;
   assign o_switch_node_hiz = !s_reg.switch_en;
   assign o_auto_bypass_en = s_reg.auto_bypass;
   assign o_output_level_code = s_reg.level;

   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (i_reset);

   AST_FORCED_PWM: assert property (
      (s_reg.pwr == PWR_ACTIVE && !s_reg.config_r[`CFG_MODE_BIT] && !forced_bypass)
      |=> o_op_mode == OP_FORCED_PWM)
      else $error("forced pwm not selected");
   AST_AUTO_MODE: assert property (
      (s_reg.pwr == PWR_ACTIVE && s_reg.config_r[`CFG_MODE_BIT] && !forced_bypass)
      |=> (o_op_mode == OP_AUTO_PWM || o_op_mode == OP_AUTO_PFM))
      else $error("auto mode not selected");
   AST_FORCED_BYPASS: assert property (
      (s_reg.pwr == PWR_ACTIVE && i_bus.wr && i_bus.addr == `OFS_LEVEL_FINE
       && i_bus.data[7:1] == `LEVEL7_BYPASS) |=> ##1 o_op_mode == OP_FORCED_BYPASS)
      else $error("fine FEh/FFh did not force bypass");
   AST_AUTO_BYPASS: assert property (
      (s_reg.pwr == PWR_ACTIVE && !s_reg.config_r[`CFG_BYPASS_BIT]) |=> o_auto_bypass_en)
      else $error("auto bypass not enabled");
   AST_PFM_ENTRY: assert property (
      $rose(s_reg.pfm) |-> $past(s_reg.sense.light_load && s_reg.sense.headroom_ok))
      else $error("pfm entered without light load and headroom");
   AST_PFM_EXIT: assert property (
      (s_reg.pfm && s_reg.sense.heavy_load) |=> !s_reg.pfm ##1 o_op_mode != OP_AUTO_PFM)
      else $error("pfm kept under heavy load");
   AST_MODE_RISE_HOLD: assert property (
      (i_bus.wr && i_bus.addr == `OFS_CONVERTER_CONFIG && i_bus.data[`CFG_MODE_BIT]
       && !s_reg.config_r[`CFG_MODE_BIT]) |=> s_reg.pwm_hold && !s_reg.pfm)
      else $error("mode rise did not force pwm");
   AST_NO_PFM_IN_BYPASS: assert property (
      forced_bypass |=> !s_reg.pfm)
      else $error("pfm entered under forced bypass");
   AST_SWITCH_ACTIVE_ONLY: assert property (
      o_switch_enable |-> $past(s_reg.pwr) == PWR_ACTIVE)
      else $error("switcher enabled outside active");
   AST_START_LOW_POWER: assert property (
      (s_reg.pwr == PWR_SHUTDOWN) |=> o_power_state == PWR_LOW_POWER)
      else $error("did not start in low power");
   AST_COARSE_LEVEL: assert property (
      (i_bus.wr && i_bus.addr == `OFS_LEVEL_COARSE)
      |=> o_output_level_code == {$past(i_bus.data[6:0]), 1'b0})
      else $error("coarse write did not clear lsb");
   AST_STANDBY_ENTRY: assert property (
      (s_reg.pwr != PWR_SHUTDOWN && i_bus.wr && i_bus.addr == `OFS_LEVEL_FINE
       && i_bus.data[7:1] == `LEVEL7_STANDBY) |=> o_power_state == PWR_STANDBY)
      else $error("fine 04h/05h did not enter standby");
   AST_ACTIVE_ENTRY: assert property (
      (s_reg.pwr != PWR_SHUTDOWN && i_bus.wr && i_bus.addr == `OFS_POWER_STATE_SELECT
       && i_bus.data[7:6] == `PSEL_ACTIVE) |=> o_power_state == PWR_ACTIVE ##1 o_switch_enable)
      else $error("power state 00b did not enter active");

   // reset checks run with the disable off, since reset is what they watch
   AST_SHUTDOWN_IN_RESET: assert property (
      @(posedge i_ref_clk) disable iff (1'b0)
      i_reset |=> o_power_state == PWR_SHUTDOWN && !o_switch_enable)
      else $error("reset did not hold shutdown");

   AST_RESET_DEFAULTS: assert property (
      @(posedge i_ref_clk) disable iff (1'b0)
      i_reset |=> s_reg.level == `RST_LEVEL && s_reg.config_r == `RST_CONFIG
      && s_reg.psel == `RST_PSEL)
      else $error("reset did not restore register defaults");

   AST_LOW_POWER_ENTRY: assert property (
      (s_reg.pwr != PWR_SHUTDOWN && i_bus.wr
       && ((i_bus.addr == `OFS_LEVEL_COARSE && i_bus.data[6:0] == `LEVEL7_LOW_POWER)
       || (i_bus.addr == `OFS_LEVEL_FINE && i_bus.data[7:1] == `LEVEL7_LOW_POWER)
       || (i_bus.addr == `OFS_POWER_STATE_SELECT
       && i_bus.data[`PSEL_MSB:`PSEL_LSB] == `PSEL_LOW_POWER)))
      |=> o_power_state == PWR_LOW_POWER)
      else $error("low power write did not enter low power");

   AST_HIZ_OUTSIDE_ACTIVE: assert property (
      (s_reg.pwr != PWR_ACTIVE) |=> o_switch_node_hiz && o_op_mode == OP_OFF)
      else $error("switch node driven outside active");

   AST_FINE_LEVEL: assert property (
      (i_bus.wr && i_bus.addr == `OFS_LEVEL_FINE)
      |=> o_output_level_code == $past(i_bus.data))
      else $error("fine write did not load level");

   AST_LEVEL_STABLE: assert property (
      !(i_bus.wr && (i_bus.addr == `OFS_LEVEL_COARSE || i_bus.addr == `OFS_LEVEL_FINE))
      |=> $stable(o_output_level_code))
      else $error("level changed without a level write");

   AST_HOLD_BLOCKS_PFM: assert property (
      (s_reg.pwm_hold && !s_reg.pfm) |=> !s_reg.pfm)
      else $error("pfm entered while pwm hold set");

   AST_TRANSIENT_PWM: assert property (
      s_reg.sense.transient |=> !s_reg.pfm && s_reg.pwm_hold)
      else $error("transient did not force pwm");

   AST_BYPASS_BIT: assert property (
      (s_reg.pwr == PWR_ACTIVE && s_reg.config_r[`CFG_BYPASS_BIT])
      |=> o_op_mode == OP_FORCED_BYPASS)
      else $error("bypass bit did not force bypass");

   AST_COARSE_BYPASS: assert property (
      (s_reg.pwr == PWR_ACTIVE && i_bus.wr && i_bus.addr == `OFS_LEVEL_COARSE
       && i_bus.data[6:0] == `LEVEL7_BYPASS) |=> ##1 o_op_mode == OP_FORCED_BYPASS)
      else $error("coarse 7Fh did not force bypass");

   AST_NO_AUTO_BYPASS: assert property (
      s_reg.config_r[`CFG_BYPASS_BIT] |=> !o_auto_bypass_en)
      else $error("auto bypass kept with bypass bit set");

   AST_CONFIG_NEXT_CYCLE: assert property (
      (i_bus.wr && i_bus.addr == `OFS_CONVERTER_CONFIG)
      |=> s_reg.config_r == $past(i_bus.data))
      else $error("config write not applied next cycle");

   AST_NO_PFM_FORCED_PWM: assert property (
      !s_reg.config_r[`CFG_MODE_BIT] |=> !s_reg.pfm)
      else $error("pfm entered with mode bit clear");

   AST_STANDBY_COARSE: assert property (
      (s_reg.pwr != PWR_SHUTDOWN && i_bus.wr && i_bus.addr == `OFS_LEVEL_COARSE
       && i_bus.data[6:0] == `LEVEL7_STANDBY) |=> o_power_state == PWR_STANDBY)
      else $error("coarse 02h did not enter standby");

   AST_SWITCH_IN_ACTIVE: assert property (
      (s_reg.pwr == PWR_ACTIVE) |=> o_switch_enable && !o_switch_node_hiz)
      else $error("switcher not enabled in active");

   AST_PFM_ONLY_ACTIVE: assert property (
      (s_reg.pwr != PWR_ACTIVE) |=> !s_reg.pfm)
      else $error("pfm kept outside active");

   AST_READ_COARSE: assert property (
      (i_bus.rd && i_bus.addr == `OFS_LEVEL_COARSE)
      |=> o_rd_data == {1'b0, $past(s_reg.level[7:1])})
      else $error("coarse read did not return upper level bits");

   AST_READ_FINE: assert property (
      (i_bus.rd && i_bus.addr == `OFS_LEVEL_FINE)
      |=> o_rd_data == $past(s_reg.level))
      else $error("fine read did not return level");
endmodule : buck_mode_power_state_ctrl
